// File: spi_host_model.sv
// spi master model: frames of up to 128 bits, msb first, sclk idling low or high
// assumes the core clock paces it and sdo arrives already resolved from its enable
`timescale 1ns/10ps
module spi_host_model (
  // pacing clock
  input wire logic i_core_clk,
  // spi pins
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_sdi,
  input wire logic i_sdo,
  input wire logic i_sdo_oe
);
  logic [127:0] tx_bits;
  logic [127:0] rx_bits;
  logic oe_in_cmd;
  logic oe_seen;
  int bit_idx;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
    oe_in_cmd = 1'b0;
    oe_seen = 1'b0;
    bit_idx = 0;
  end
  always @(posedge i_core_clk) begin
    if (!o_cs_n && i_sdo_oe) begin
      oe_seen <= 1'b1;
      if (bit_idx < 16) oe_in_cmd <= 1'b1;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // low phase of 5 cycles lets sdo, which lags the fall by 3, settle
  task automatic frame(input logic idle_hi, input int nbits);
    bit_idx = 0;
    o_sclk <= idle_hi;
    tick(3);
    o_cs_n <= 1'b0;
    oe_in_cmd = 1'b0;
    oe_seen = 1'b0;
    tick(3);
    for (int i = 0; i < nbits; i++) begin
      bit_idx = i;
      o_sclk <= 1'b0;
      o_sdi <= tx_bits[127-i];
      tick(5);
      o_sclk <= 1'b1;
      rx_bits[127-i] = i_sdo;
      tick(3);
    end
    o_sclk <= idle_hi;
    tick(8);
    o_cs_n <= 1'b1;
    o_sdi <= ~o_sdi;
    tick(6);
  endtask
endmodule

// File: spi_pin_sync.sv
// two flip-flop synchroniser for a group of pins from outside the core clock domain
// assumes pins are quasi-static relative to the core clock (link slower by several times)
`timescale 1ns/10ps
module spi_pin_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // pins in, synchronised out
  input wire logic [W-1:0] i_pins,
  output logic [W-1:0] o_pins_s
);
  logic [W-1:0] meta;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          meta[g] <= RST_VAL[g];
          o_pins_s[g] <= RST_VAL[g];
        end else if (i_ce) begin
          meta[g] <= i_pins[g];
          o_pins_s[g] <= meta[g];
        end
      end
    end
  endgenerate
endmodule

// File: spi_port_pkg.sv
// types shared by the spi register access port
// assumes nothing; the state width is fixed here at 5 bits
package spi_port_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CMD = 5'h02,
    ST_WR = 5'h04,
    ST_RD = 5'h08,
    ST_SKIP = 5'h10
  } port_state_t;
endpackage

// File: spi_port_regs.svh
// constants of the spi register access port: command word layout, word size, timing
// assumes nothing; included by its bare name
`ifndef SPI_PORT_REGS_SVH
`define SPI_PORT_REGS_SVH

`define SPI_WORD_BITS 16
`define SPI_ADDR_BITS 10
`define SPI_CMD_EN_HI 15
`define SPI_CMD_EN_LO 11
`define SPI_CMD_RW_BIT 10
`define SPI_CMD_ADDR_HI 9
`define SPI_CMD_ENABLE_PAT 5'h1C
`define SPI_CMD_RW_READ 1'h1
`define SPI_LAST_BIT 4'hF
`define SPI_MAX_ADDR_DEF 10'h3FF
`define SPI_SYNC_RST 3'h4
`define SPI_CORE_CLK_NS 20
`define SPI_LINK_CLK_NS 160
`define SPI_CLKS_PER_LINK (`SPI_LINK_CLK_NS / `SPI_CORE_CLK_NS)

`endif

// File: spi_register_access_port.sv
// spi slave port giving a host read and write access to 16-bit internal registers
// assumes a register file that answers i_reg_rdata combinationally from o_reg_addr
// and takes o_reg_wdata on the o_reg_wr pulse; sclk runs well below core clock / 4
//
// Notes on behaviour
// - sdi is taken on rising sclk, sdo changes on falling sclk.
// - command bits 15..11 must hold 11100 or no transaction starts.
// - command bit 10 high means read, low means write.
// - command bits 9..0 load the address pointer for the first register.
// - a write shifts in a 16-bit word and stores it at the pointer.
// - further write words go to successive registers after pointer increment.
// - a write accepts words until chip select rises or the top register is written.
// - pointer never wraps; writes beyond the top register are discarded.
// - framing works whether sclk idles high or low.
// - reads need 16 sclk pulses per word, shifted out on sdo.
// - first read bit follows the last command bit with no dummy cycles.
// - read pointer advances by one after each 16-bit word sent below the top address.
// - a read ends when chip select rises.
// - at the top address a read keeps sending the last register.
// - sdo is high impedance except while shifting read data.
// - every register is 16 bits, one per data word.
`timescale 1ns/10ps
`include "spi_port_regs.svh"
module spi_register_access_port #(
  parameter logic [`SPI_ADDR_BITS-1:0] MAX_ADDR = `SPI_MAX_ADDR_DEF
) (
  // clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // spi pins
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sclk,
  input wire logic i_spi_sdi,
  output logic o_spi_sdo,
  output logic o_spi_sdo_oe,
  // register file
  output logic [`SPI_ADDR_BITS-1:0] o_reg_addr,
  output logic o_reg_wr,
  output logic [`SPI_WORD_BITS-1:0] o_reg_wdata,
  input wire logic [`SPI_WORD_BITS-1:0] i_reg_rdata
);
  spi_port_pkg::port_state_t st;
  logic [2:0] pins_s;
  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;
  logic sclk_d;
  logic rise;
  logic fall;
  logic [3:0] bit_cnt;
  logic [3:0] tx_cnt;
  logic [`SPI_WORD_BITS-1:0] rx_shift;
  logic [`SPI_WORD_BITS-1:0] tx_shift;
  logic [`SPI_WORD_BITS-1:0] next_word;
  logic word_done;
  logic cmd_ok;
  logic at_top;
  logic full;

  spi_pin_sync #(
    .W(3),
    .RST_VAL(`SPI_SYNC_RST)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_pins({i_spi_cs_n, i_spi_sclk, i_spi_sdi}),
    .o_pins_s(pins_s)
  );

  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign sdi_s = pins_s[0];

  // edges count only while selected, so the idle sclk level never forms a bit
  assign rise = sclk_s & ~sclk_d & ~cs_n_s;
  assign fall = ~sclk_s & sclk_d & ~cs_n_s;
  assign next_word = {rx_shift[`SPI_WORD_BITS-2:0], sdi_s};
  assign word_done = rise && (bit_cnt == `SPI_LAST_BIT);
  assign cmd_ok = next_word[`SPI_CMD_EN_HI:`SPI_CMD_EN_LO] == `SPI_CMD_ENABLE_PAT;
  assign at_top = o_reg_addr == MAX_ADDR;
  assign o_spi_sdo = tx_shift[`SPI_WORD_BITS-1];

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sclk_d <= 1'h0;
    end else if (i_ce) begin
      sclk_d <= sclk_s;
    end
  end

  // framing: a raised chip select ends any transaction, mid-word or not
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= spi_port_pkg::ST_IDLE;
    end else if (i_ce) begin
      if (cs_n_s) begin
        st <= spi_port_pkg::ST_IDLE;
      end else begin
        case (st)
          spi_port_pkg::ST_IDLE: begin
            st <= spi_port_pkg::ST_CMD;
          end
          spi_port_pkg::ST_CMD: begin
            if (word_done) begin
              if (!cmd_ok) begin
                st <= spi_port_pkg::ST_SKIP;
              end else if (next_word[`SPI_CMD_RW_BIT] == `SPI_CMD_RW_READ) begin
                st <= spi_port_pkg::ST_RD;
              end else begin
                st <= spi_port_pkg::ST_WR;
              end
            end
          end
          spi_port_pkg::ST_WR, spi_port_pkg::ST_RD, spi_port_pkg::ST_SKIP: begin
            st <= st;
          end
          default: begin
            st <= spi_port_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // receive side: msb first, one bit per rising edge
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bit_cnt <= 4'h0;
      rx_shift <= 16'h0000;
    end else if (i_ce) begin
      if (st == spi_port_pkg::ST_IDLE) begin
        bit_cnt <= 4'h0;
      end else if (rise) begin
        bit_cnt <= 4'(bit_cnt + 4'h1);
        rx_shift <= next_word;
      end
    end
  end

  // write strobe: only complete words, never once the top register was written
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_wr <= 1'h0;
      o_reg_wdata <= 16'h0000;
    end else if (i_ce) begin
      o_reg_wr <= 1'h0;
      if (st == spi_port_pkg::ST_WR && word_done && !full) begin
        o_reg_wr <= 1'h1;
        o_reg_wdata <= next_word;
      end
    end
  end

  // address pointer: saturates at the top instead of wrapping
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_addr <= 10'h000;
      full <= 1'h0;
    end else if (i_ce) begin
      if (st == spi_port_pkg::ST_CMD && word_done) begin
        o_reg_addr <= next_word[`SPI_CMD_ADDR_HI:0];
        full <= 1'h0;
      end else if (o_reg_wr) begin
        if (at_top) begin
          full <= 1'h1;
        end else begin
          o_reg_addr <= 10'(o_reg_addr + 10'h001);
        end
      end else if (st == spi_port_pkg::ST_RD && word_done && !at_top) begin
        o_reg_addr <= 10'(o_reg_addr + 10'h001);
      end
    end
  end

  // transmit side: first fall after the command and every 16th after it load a word, other falls shift
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_cnt <= 4'h0;
      tx_shift <= 16'h0000;
      o_spi_sdo_oe <= 1'h0;
    end else if (i_ce) begin
      if (st != spi_port_pkg::ST_RD) begin
        tx_cnt <= 4'h0;
        o_spi_sdo_oe <= 1'h0;
      end else if (fall) begin
        tx_cnt <= 4'(tx_cnt + 4'h1);
        o_spi_sdo_oe <= 1'h1;
        if (tx_cnt == 4'h0) begin
          tx_shift <= i_reg_rdata;
        end else begin
          tx_shift <= {tx_shift[`SPI_WORD_BITS-2:0], 1'h0};
        end
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst || !i_ce);

  sdo_quiet_a: assert property (
    st != spi_port_pkg::ST_RD |=> !o_spi_sdo_oe)
    else $error("sdo driven outside read data");

  first_bit_a: assert property (
    (st == spi_port_pkg::ST_RD && fall && tx_cnt == 4'h0)
      |=> o_spi_sdo_oe && o_spi_sdo == $past(i_reg_rdata[15]))
    else $error("first read bit not presented on first fall");

  bad_cmd_a: assert property (
    (st == spi_port_pkg::ST_CMD && word_done && !cmd_ok && !cs_n_s)
      |=> st == spi_port_pkg::ST_SKIP)
    else $error("bad enable pattern did not block transaction");

  skip_silent_a: assert property (
    st == spi_port_pkg::ST_SKIP |=> !o_reg_wr && !o_spi_sdo_oe)
    else $error("ignored transaction caused activity");

  wr_incr_a: assert property (
    (o_reg_wr && !at_top) |=> o_reg_addr == 10'($past(o_reg_addr) + 10'h001))
    else $error("pointer did not advance after write");

  no_write_past_top_a: assert property (
    full |-> !o_reg_wr)
    else $error("write beyond top register");

  rd_stays_top_a: assert property (
    (st == spi_port_pkg::ST_RD && at_top) |=> o_reg_addr == MAX_ADDR || $past(word_done) == 1'h0
      && o_reg_addr == MAX_ADDR)
    else $error("read pointer left top register");

  rd_incr_a: assert property (
    (st == spi_port_pkg::ST_RD && word_done && !at_top && !cs_n_s)
      |=> o_reg_addr == 10'($past(o_reg_addr) + 10'h001))
    else $error("read pointer did not advance after a word");

  deselect_a: assert property (
    cs_n_s |=> st == spi_port_pkg::ST_IDLE ##1 !o_spi_sdo_oe)
    else $error("chip select high did not end transaction");

  wr_word_a: assert property (
    o_reg_wr |-> $past(st) == spi_port_pkg::ST_WR && o_reg_wdata == $past(next_word))
    else $error("write strobe without a complete word");

  cmd_start_a: assert property (
    (st == spi_port_pkg::ST_IDLE && !cs_n_s) |=> st == spi_port_pkg::ST_CMD)
    else $error("selected port did not start a command word");

  addr_load_a: assert property (
    (st == spi_port_pkg::ST_CMD && word_done && cmd_ok)
      |=> o_reg_addr == $past(next_word[`SPI_CMD_ADDR_HI:0]))
    else $error("pointer not loaded from command word");

  rd_select_a: assert property (
    (st == spi_port_pkg::ST_CMD && word_done && cmd_ok && next_word[`SPI_CMD_RW_BIT])
      |=> st == spi_port_pkg::ST_RD)
    else $error("read command did not enter read state");

  wr_select_a: assert property (
    (st == spi_port_pkg::ST_CMD && word_done && cmd_ok && !next_word[`SPI_CMD_RW_BIT])
      |=> st == spi_port_pkg::ST_WR)
    else $error("write command did not enter write state");

  wr_bits_a: assert property (
    o_reg_wr |-> $past(rise) && $past(bit_cnt) == `SPI_LAST_BIT)
    else $error("write strobe before sixteenth data bit");

  top_full_a: assert property (
    (o_reg_wr && at_top) |=> full && o_reg_addr == MAX_ADDR)
    else $error("write at top register did not stop the pointer");

  abort_no_wr_a: assert property (
    cs_n_s |=> !o_reg_wr)
    else $error("register written after chip select rose");

  sdo_hold_a: assert property (
    (st == spi_port_pkg::ST_RD && !fall) |=> $stable(o_spi_sdo))
    else $error("sdo changed without a falling sclk");

  tx_shift_a: assert property (
    (st == spi_port_pkg::ST_RD && fall && tx_cnt != 4'h0)
      |=> o_spi_sdo == $past(tx_shift[`SPI_WORD_BITS-2]))
    else $error("read word not shifted msb first");

  // own clock and disable: the default disable would switch this check off
  // exactly while the enable is low, which is when it has something to say
  freeze_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    !i_ce |=> $stable(st) && $stable(bit_cnt) && $stable(o_reg_addr)
      && $stable(o_reg_wr) && $stable(o_spi_sdo_oe) && $stable(tx_shift))
    else $error("state moved while clock enable low");

  cov_write_c: cover property (o_reg_wr ##[1:400] o_reg_wr);
  cov_read_c: cover property (st == spi_port_pkg::ST_RD && word_done);
  cov_skip_c: cover property (st == spi_port_pkg::ST_SKIP);
  cov_top_c: cover property (full);
  cov_abort_c: cover property (st == spi_port_pkg::ST_WR && cs_n_s);
endmodule

// File: spi_register_access_port_tb.sv
// self-checking bench for the spi register access port with a small register file
// assumes the host model drives the pins; top address shortened to 3
`timescale 1ns/10ps
module spi_register_access_port_tb;
  logic i_core_clk;
  logic i_nrst;
  logic i_ce;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  wire sdo_pin;
  logic [9:0] reg_addr;
  logic reg_wr;
  logic [15:0] reg_wdata;
  logic [15:0] mem [0:15];
  logic [15:0] exp_mem [0:15];
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  // no pull on sdo, so a released pin reads as z
  assign sdo_pin = sdo_oe ? sdo : 1'bz;
  spi_register_access_port #(.MAX_ADDR(10'h003)) dut (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_ce(i_ce),
    .i_spi_cs_n(cs_n), .i_spi_sclk(sclk), .i_spi_sdi(sdi),
    .o_spi_sdo(sdo), .o_spi_sdo_oe(sdo_oe), .o_reg_addr(reg_addr),
    .o_reg_wr(reg_wr), .o_reg_wdata(reg_wdata), .i_reg_rdata(mem[reg_addr[3:0]]));
  spi_host_model host (.i_core_clk(i_core_clk), .o_cs_n(cs_n), .o_sclk(sclk),
    .o_sdi(sdi), .i_sdo(sdo_pin), .i_sdo_oe(sdo_oe));
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) if (reg_wr === 1'b1) mem[reg_addr[3:0]] <= reg_wdata;
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_mem;
    for (int i = 0; i < 4; i++) check(mem[i], exp_mem[i]);
  endtask
  task automatic t_bad_cmd;
    host.tx_bits = {5'h1E, 1'h0, 10'h000, 16'hDEAD, 96'h0};
    host.frame(1'b0, 32);
    check_mem();
    host.tx_bits = {5'h1D, 1'h1, 10'h000, 112'h0};
    host.frame(1'b1, 32);
    check({15'h0000, host.oe_seen}, 16'h0000);
    $display("bad command done");
  endtask
  task automatic t_abort;
    host.tx_bits = {5'h1C, 1'h0, 10'h001, 16'hBEEF, 96'h0};
    host.frame(1'b0, 24);
    check_mem();
    host.tx_bits = {5'h1C, 1'h0, 10'h001, 16'hA5C3, 96'h0};
    host.frame(1'b0, 32);
    exp_mem[1] = 16'hA5C3;
    check_mem();
    $display("abort and single write done");
  endtask
  task automatic t_write_burst;
    host.tx_bits = {5'h1C, 1'h0, 10'h002, 16'h1234, 16'h5678, 16'h9ABC, 64'h0};
    host.frame(1'b1, 64);
    exp_mem[2] = 16'h1234;
    exp_mem[3] = 16'h5678;
    check_mem();
    $display("burst write done");
  endtask
  task automatic t_read_burst;
    host.tx_bits = {5'h1C, 1'h1, 10'h002, 112'h0};
    host.frame(1'b0, 64);
    check(host.rx_bits[111:96], exp_mem[2]);
    check(host.rx_bits[95:80], exp_mem[3]);
    check(host.rx_bits[79:64], exp_mem[3]);
    check({15'h0000, host.oe_in_cmd}, 16'h0000);
    check({15'h0000, sdo_oe}, 16'h0000);
    $display("burst read done");
  endtask
  task automatic t_read_single;
    host.tx_bits = {5'h1C, 1'h1, 10'h000, 112'h0};
    host.frame(1'b1, 32);
    check(host.rx_bits[111:96], exp_mem[0]);
    $display("single read done");
  endtask
  // a full write frame sent while the enable is low must leave no trace
  task automatic t_freeze;
    i_ce <= 1'b0;
    host.tx_bits = {5'h1C, 1'h0, 10'h000, 16'h5A5A, 96'h0};
    host.frame(1'b0, 32);
    i_ce <= 1'b1;
    host.tick(4);
    check_mem();
    $display("clock enable freeze done");
  endtask
  initial begin
    i_nrst = 1'b0;
    i_ce = 1'b1;
    for (int i = 0; i < 16; i++) begin
      mem[i] = {12'hC50, i[3:0]};
      exp_mem[i] = {12'hC50, i[3:0]};
    end
    repeat (12) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    t_bad_cmd();
    t_abort();
    t_write_burst();
    t_read_burst();
    t_read_single();
    t_freeze();
    wrap_up();
  end
endmodule
